// ---- core/mcu_decode_pkg.sv ----
// Purpose: Shared constants and types for the instruction sequencer
// Assumes: 13-bit words, 8-bit data, 32-bit APB data bus
// Notes:   Flag bits live in register file entry 3
package mcu_decode_pkg;
   localparam int IW = 13;                // Instruction word width
   localparam int DW = 8;                 // Data width
   localparam int PCW = 13;               // Program counter width
   // APB byte offsets
   localparam logic [7:0] A_CTRL = 8'h00; // Control, read/write
   localparam logic [7:0] A_STAT = 8'h04; // Core state, read only
   localparam logic [7:0] A_PC = 8'h08;   // Program counter, read only
   localparam logic [1:0] CTRL_RST = 2'h1; // Run on, two-clock cycle
   // Special register addresses
   localparam logic [5:0] R_PC = 6'h02;   // Program counter low byte
   localparam logic [5:0] R_STAT = 6'h03; // Flags
   localparam logic [5:0] R_PAGE = 6'h05; // Page bits 7:5
   // Flag bit positions
   localparam int F_C = 0;
   localparam int F_DC = 1;
   localparam int F_Z = 2;
   localparam int F_P = 3;
   localparam int F_T = 4;
   // Control registers reachable by the I/O control moves
   localparam logic [15:0] IOC_OK = 16'hfce0;
   // Special opcodes, low six bits of 13'h00xx
   localparam logic [5:0] DECIMAL_ADJUST_ACC = 6'h01;
   localparam logic [5:0] CONTROL_WRITE_INSTR = 6'h02;
   localparam logic [5:0] SLEEP_INSTR = 6'h03;
   localparam logic [5:0] WATCHDOG_CLEAR_INSTR = 6'h04;
   localparam logic [5:0] INTERRUPT_ENABLE_INSTR = 6'h10;
   localparam logic [5:0] INTERRUPT_DISABLE_INSTR = 6'h11;
   localparam logic [5:0] RETURN_INSTR = 6'h12;
   localparam logic [5:0] RETURN_FROM_INTERRUPT = 6'h13;
   localparam logic [5:0] CONTROL_READ_INSTR = 6'h14;
   // Shared ALU operations, coded as word bits 10:7
   typedef enum logic [3:0] {
      SUBR = 4'h2, DECR = 4'h3, ORR = 4'h4, ANDR = 4'h5, XORR = 4'h6,
      ADDR = 4'h7, MOVR = 4'h8, COMR = 4'h9, INCR = 4'ha,
      DECREMENT_SKIP_ZERO = 4'hb, ROTATE_RIGHT_CARRY = 4'hc,
      ROTATE_LEFT_CARRY = 4'hd, SWAPR = 4'he, INCREMENT_SKIP_ZERO = 4'hf
   } alu_e;
   // Oscillator phase within one instruction cycle
   typedef enum logic [1:0] {
      PH0 = 2'b00, PH1 = 2'b01, PH2 = 2'b11, PH3 = 2'b10
   } phase_e;
   // Software control bits
   typedef struct packed {
      logic cyc4;                          // Four clocks per cycle
      logic run;                           // Execute enable
   } ctrl_s;
endpackage : mcu_decode_pkg

// ---- core/mcu_decode_exec.sv ----
// Purpose: Decode and sequence 13-bit instructions of an 8-bit core
// Assumes: Program memory answers PM_ADDR_OUT within one clock
// Notes:   Registers over APB; I/O registers share the register file
// Operation
// RL1: Thirteen-bit words, opcode plus operand fields
// RL2: Default cycle two clocks, one cycle each
// RL3: Writes to program counter take two cycles
// RL4: Jumps, calls, returns, taken skips: two cycles
// RL5: Option bit selects two or four clocks
// RL6: Timer tick every cycle, Fosc/2 or /4
// RL7: Any register bit set, clear, test
// RL8: I/O registers behave as ordinary registers
// RL9: Eight-bit data literals, ten-bit jump targets
// RL10: Sleep clears watchdog, stops clock, sets flags
// RL11: Returns pop stack; interrupt return enables
// RL12: Call pushes next address, then jumps
// RL13: Decrement-skip writes, skips on zero, no flags
// RL14: Increment-skip writes, skips on zero, no flags
// RL15: Rotates run through the carry flag
// RL16: Control moves reach listed control registers
// RL17: Software avoids bit clear on interrupt status
// RL18: Software never bit-sets interrupt status
// RL19: Skip discards the fetched word as no-op
// RL20: Register field low six; borrow clears carry
`timescale 1ns/100ps
module mcu_decode_exec
   import mcu_decode_pkg::*;
#(
   parameter int STACK_DEPTH = 8           // Return stack entries
)(
   input  wire logic            MCLK_IN,       // Oscillator clock
   input  wire logic            RST_IN,        // Core reset
   input  wire logic            PSEL_IN,       // APB select
   input  wire logic            PENABLE_IN,    // APB enable
   input  wire logic            PWRITE_IN,     // APB direction
   input  wire logic [7:0]      PADDR_IN,      // APB byte address
   input  wire logic [31:0]     PWDATA_IN,     // APB write data
   input  wire logic [IW-1:0]   PM_DATA_IN,    // Fetched word
   output logic                 PREADY_OUT,    // APB ready
   output logic                 PSLVERR_OUT,   // APB error
   output logic [31:0]          PRDATA_OUT,    // APB read data
   output logic [PCW-1:0]       PM_ADDR_OUT,   // Fetch address
   output logic                 WDT_CLEAR_OUT, // Watchdog clear pulse
   output logic                 SLEEP_OUT,     // Oscillator stopped
   output logic                 INT_EN_OUT,    // Interrupts enabled
   output logic                 TIMER_TICK_OUT // Timer clock pulse
);
   localparam int SPW = $clog2(STACK_DEPTH);

   // Refuse stack sizes the wrapping pointer cannot serve
   if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
   begin : g_chk
      $error("STACK_DEPTH must be a power of two, at least 2");
   end

   phase_e           ph_q, ph_d;          // Oscillator phase
   ctrl_s            ctrl_q, ctrl_d;      // Software control
   logic             cyc4_q;              // Cycle length in use
   logic [PCW-1:0]   pc_q, pc_d;          // Program counter
   logic [DW-1:0]    acc_q, acc_d;        // Accumulator
   logic [DW-1:0]    rf_q [64];           // Registers incl. I/O
   logic [DW-1:0]    ioc_q [16];          // I/O control registers
   logic [DW-1:0]    cont_q, cont_d;      // Control register
   logic [PCW-1:0]   stk_q [STACK_DEPTH]; // Return stack
   logic [SPW-1:0]   sp_q, sp_d;          // Stack pointer
   logic             flush_q, flush_d;    // Discard next word
   logic             hold_q, hold_d;      // Dead cycle, pc held
   logic             ie_q, ie_d;          // Interrupt enable
   logic             sleep_q, sleep_d;    // Sleeping
   logic             wdc_q, wdc_d;        // Watchdog clear
   logic             tick_q;              // Timer tick
   logic             rdy_q, err_q;        // APB answer
   logic [31:0]      rd_q, rd_d;          // APB read data
   logic             rf_we, ioc_we, push; // Write strobes
   logic [5:0]       rf_wa;               // Register write address
   logic [DW-1:0]    rf_wd, st_d;         // Write data, next flags
   logic             upd_z, upd_c, upd_dc; // Flag update selects
   logic             skip;                // Skip condition true
   logic             end_ph, cyc_end, ex; // Cycle end, execute
   logic             apb_go, apb_hit, apb_err;
   alu_e             op;                  // Shared ALU operation
   logic             cn, dn;              // ALU carry, half carry
   logic [DW-1:0]    res;                 // ALU result
   logic [8:0]       dv;                  // Decimal adjust sum
   logic [IW-1:0]    w;                   // Word being executed
   logic [5:0]       ra;                  // Register field
   logic [DW-1:0]    rv, k;               // Operand, literal
   logic             cf, dcf;             // Current carry flags
   logic [PCW-1:0]   pcn, tgt, stk_top;   // Next, target, top
   logic [SPW-1:0]   sp_m1;               // Top entry index

   assign w = PM_DATA_IN;                        // [RL1]
   assign ra = w[5:0];                           // [RL20]
   assign k = w[7:0];                            // [RL9]
   // Program counter low byte reads as register 2
   assign rv = (ra == R_PC) ? pc_q[7:0] : rf_q[ra]; // [RL8]
   assign cf = rf_q[R_STAT][F_C];
   assign dcf = rf_q[R_STAT][F_DC];
   assign pcn = pc_q + 13'h0001;
   assign tgt = {rf_q[R_PAGE][7:5], w[9:0]};     // [RL9]
   assign sp_m1 = sp_q - 1'b1;
   assign stk_top = stk_q[sp_m1];
   // Cycle ends after two or four phases
   assign end_ph = (ph_q == PH3) || (ph_q == PH1 && !cyc4_q); // [RL5]
   assign cyc_end = end_ph && !sleep_q;
   assign ex = cyc_end && ctrl_q.run;

   // Shared ALU: returns carry, half carry and result
   function automatic logic [9:0] alu(input alu_e o, input logic [7:0] x,
      input logic [7:0] a, input logic ci, input logic di);
      logic [8:0] s;
      logic [4:0] h;
      s = {ci, x};
      h = {di, 4'h0};
      unique case (o)
         SUBR:
         begin
            s = {1'b0, x} + {1'b0, ~a} + 9'h001;   // [RL20]
            h = {1'b0, x[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
         end
         ADDR:
         begin
            s = {1'b0, x} + {1'b0, a};
            h = {1'b0, x[3:0]} + {1'b0, a[3:0]};
         end
         DECR, DECREMENT_SKIP_ZERO: s = {ci, x - 8'h01};
         INCR, INCREMENT_SKIP_ZERO: s = {ci, x + 8'h01};
         ORR:  s = {ci, x | a};
         ANDR: s = {ci, x & a};
         XORR: s = {ci, x ^ a};
         MOVR: s = {ci, x};
         COMR: s = {ci, ~x};
         ROTATE_RIGHT_CARRY: s = {x[0], ci, x[7:1]}; // [RL15]
         ROTATE_LEFT_CARRY:  s = {x[7], x[6:0], ci}; // [RL15]
         SWAPR: s = {ci, x[3:0], x[7:4]};
         default: s = {ci, x};
      endcase
      return {s[8], h[4], s[7:0]};
   endfunction : alu

   // Literal forms map onto the register-form operation codes
   always_comb
   begin
      op = alu_e'(w[10:7]);
      if (w[12])
      begin
         case (w[10:8])
            3'h1:    op = ORR;
            3'h2:    op = ANDR;
            3'h3:    op = XORR;
            3'h5:    op = SUBR;
            3'h7:    op = ADDR;
            default: op = MOVR;
         endcase
      end
   end

   assign {cn, dn, res} = alu(op, w[12] ? k : rv, acc_q, cf, dcf);

   // Phase sequence; the oscillator stops while sleeping
   always_comb
   begin
      unique case (ph_q)
         PH0: ph_d = PH1;
         PH1: ph_d = cyc4_q ? PH2 : PH0;            // [RL2] [RL5]
         PH2: ph_d = PH3;
         PH3: ph_d = PH0;
      endcase
      if (sleep_q)
         ph_d = ph_q;                               // [RL10]
   end

   // Instruction execute at each cycle end while run is set
   always_comb
   begin
      pc_d = pc_q;
      acc_d = acc_q;
      st_d = rf_q[R_STAT];
      cont_d = cont_q;
      rf_we = 1'b0;
      rf_wa = ra;
      rf_wd = res;
      ioc_we = 1'b0;
      push = 1'b0;
      sp_d = sp_q;
      ie_d = ie_q;
      sleep_d = sleep_q;
      wdc_d = 1'b0;
      flush_d = flush_q;
      hold_d = hold_q;
      upd_z = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      skip = 1'b0;
      dv = {1'b0, acc_q};
      if (ex)
      begin
         flush_d = 1'b0;
         hold_d = 1'b0;
         if (!hold_q)
            pc_d = pcn;                             // [RL2]
         // Discarded words act as no-ops
         if (!flush_q && !hold_q)                   // [RL19]
         begin
            if (w[12:8] == 5'h00)
            begin
               unique case (w[7:6])
                  2'b00:
                  begin
                     case (w[5:0])
                        DECIMAL_ADJUST_ACC:
                        begin
                           if (acc_q[3:0] > 4'h9 || dcf)
                              dv = dv + 9'h006;
                           if (dv[7:4] > 4'h9 || cf || dv[8])
                              dv = dv + 9'h060;
                           acc_d = dv[7:0];
                           st_d[F_C] = dv[8] | cf;
                        end
                        CONTROL_WRITE_INSTR: cont_d = acc_q;
                        CONTROL_READ_INSTR:  acc_d = cont_q;
                        SLEEP_INSTR:
                        begin
                           sleep_d = 1'b1;                  // [RL10]
                           wdc_d = 1'b1;
                           st_d[F_T] = 1'b1;
                           st_d[F_P] = 1'b0;
                        end
                        WATCHDOG_CLEAR_INSTR:
                        begin
                           wdc_d = 1'b1;
                           st_d[F_T] = 1'b1;
                           st_d[F_P] = 1'b1;
                        end
                        INTERRUPT_ENABLE_INSTR:  ie_d = 1'b1;
                        INTERRUPT_DISABLE_INSTR: ie_d = 1'b0;
                        RETURN_INSTR, RETURN_FROM_INTERRUPT:
                        begin
                           pc_d = stk_top;                  // [RL11]
                           sp_d = sp_m1;
                           hold_d = 1'b1;                   // [RL4]
                           if (w[0])
                              ie_d = 1'b1;                  // [RL11]
                        end
                        default:
                        begin
                           // Control moves to listed registers; other codes are no-ops
                           if (!w[5] && IOC_OK[w[3:0]])     // [RL16]
                           begin
                              ioc_we = !w[4];
                              if (w[4])
                                 acc_d = ioc_q[w[3:0]];
                           end
                        end
                     endcase
                  end
                  2'b01:
                  begin
                     rf_we = 1'b1;
                     rf_wd = acc_q;
                  end
                  2'b10:
                  begin
                     if (ra == 6'h00)
                     begin
                        acc_d = 8'h00;
                        st_d[F_Z] = 1'b1;
                     end
                  end
                  2'b11:
                  begin
                     rf_we = 1'b1;
                     rf_wd = 8'h00;
                     st_d[F_Z] = 1'b1;
                  end
               endcase
            end
            else if (w[12:11] == 2'b00)
            begin
               // Register operations, result to A or R
               upd_z = (w[10:7] <= INCR);           // [RL13] [RL14]
               upd_c = (op == SUBR || op == ADDR ||
                        op == ROTATE_RIGHT_CARRY ||
                        op == ROTATE_LEFT_CARRY);   // [RL15]
               upd_dc = (op == SUBR || op == ADDR);
               skip = (op == DECREMENT_SKIP_ZERO ||
                       op == INCREMENT_SKIP_ZERO) &&
                      res == 8'h00;                 // [RL13] [RL14]
               rf_we = w[6];
               if (!w[6])
                  acc_d = res;
            end
            else if (!w[12])
            begin
               // Bit operations on any register
               unique case (w[10:9])                // [RL7]
                  2'b00:
                  begin
                     rf_we = 1'b1;
                     rf_wd = rv & ~(8'h01 << w[8:6]);
                  end
                  2'b01:
                  begin
                     rf_we = 1'b1;
                     rf_wd = rv | (8'h01 << w[8:6]);
                  end
                  2'b10: skip = !rv[w[8:6]];
                  2'b11: skip = rv[w[8:6]];
               endcase
            end
            else if (!w[11])
            begin
               // Call pushes the return address
               push = !w[10];                       // [RL12]
               if (!w[10])
                  sp_d = sp_q + 1'b1;
               pc_d = tgt;                          // [RL12]
               hold_d = 1'b1;                       // [RL4]
            end
            else if (w[10:8] == 3'h6 && w[7:4] == 4'h8)
            begin
               rf_we = 1'b1;
               rf_wa = R_PAGE;
               rf_wd = {w[2:0], rf_q[R_PAGE][4:0]};
            end
            else if (w[10:8] == 3'h6)
            begin
               if (w[7:1] == 7'h48)
                  st_d[7:6] = {1'b0, w[0]};
            end
            else if (w[10:8] == 3'h4)
            begin
               acc_d = k;                           // [RL11]
               pc_d = stk_top;
               sp_d = sp_m1;
               hold_d = 1'b1;                       // [RL4]
            end
            else
            begin
               // Literal arithmetic and logic
               acc_d = res;
               upd_z = (op != MOVR);
               upd_c = (op == SUBR || op == ADDR);
               upd_dc = upd_c;
            end
            if (upd_z)
               st_d[F_Z] = (res == 8'h00);
            if (upd_c)
               st_d[F_C] = cn;
            if (upd_dc)
               st_d[F_DC] = dn;
            if (skip)
               flush_d = 1'b1;                      // [RL19] [RL4]
            if (rf_we && rf_wa == R_PC)
            begin
               pc_d = {pc_q[12:8], rf_wd};          // [RL3]
               hold_d = 1'b1;
            end
         end
      end
   end

   // APB decode; write to read-only or unmapped is an error
   always_comb
   begin
      apb_go = PSEL_IN && PENABLE_IN && !rdy_q;
      apb_hit = (PADDR_IN == A_CTRL) || (PADDR_IN == A_STAT) ||
                (PADDR_IN == A_PC);
      apb_err = !apb_hit || (PWRITE_IN && PADDR_IN != A_CTRL);
      ctrl_d = ctrl_q;
      rd_d = 32'h0000_0000;
      // Write commits at the edge where the master sees ready
      if (PSEL_IN && PENABLE_IN && rdy_q && PWRITE_IN &&
          PADDR_IN == A_CTRL)
         ctrl_d = PWDATA_IN[1:0];                   // [RL5]
      if (apb_go && !PWRITE_IN)
      begin
         if (PADDR_IN == A_CTRL)
            rd_d = {30'h0, ctrl_q};
         else if (PADDR_IN == A_STAT)
            rd_d = {14'h0, rf_q[R_STAT], ie_q, sleep_q, acc_q};
         else if (PADDR_IN == A_PC)
            rd_d = {19'h0, pc_q};
      end
   end

   // State registers
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         ph_q <= PH0;
         ctrl_q <= CTRL_RST;
         cyc4_q <= 1'b0;
         pc_q <= 13'h0000;
         acc_q <= 8'h00;
         cont_q <= 8'h00;
         sp_q <= '0;
         flush_q <= 1'b0;
         hold_q <= 1'b0;
         ie_q <= 1'b0;
         sleep_q <= 1'b0;
         wdc_q <= 1'b0;
         tick_q <= 1'b0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         for (int i = 0; i < 64; i++)
            rf_q[i] <= 8'h00;
         for (int i = 0; i < 16; i++)
            ioc_q[i] <= 8'h00;
         for (int i = 0; i < STACK_DEPTH; i++)
            stk_q[i] <= 13'h0000;
      end
      else
      begin
         ph_q <= ph_d;
         ctrl_q <= ctrl_d;
         if (cyc_end)
            cyc4_q <= ctrl_q.cyc4;                  // [RL5]
         pc_q <= pc_d;
         acc_q <= acc_d;
         cont_q <= cont_d;
         sp_q <= sp_d;
         flush_q <= flush_d;
         hold_q <= hold_d;
         ie_q <= ie_d;
         sleep_q <= sleep_d;
         wdc_q <= wdc_d;
         tick_q <= cyc_end;                         // [RL6]
         rdy_q <= apb_go;
         err_q <= apb_go && apb_err;
         rd_q <= rd_d;
         rf_q[R_STAT] <= st_d;
         if (rf_we)
            rf_q[rf_wa] <= rf_wd;                   // [RL8]
         if (ioc_we)
            ioc_q[w[3:0]] <= acc_q;                 // [RL16]
         if (push)
            stk_q[sp_q] <= pcn;                     // [RL12]
      end
   end

   assign PREADY_OUT = rdy_q;
   assign PSLVERR_OUT = err_q;
   assign PRDATA_OUT = rd_q;
   assign PM_ADDR_OUT = pc_q;
   assign WDT_CLEAR_OUT = wdc_q;
   assign SLEEP_OUT = sleep_q;
   assign INT_EN_OUT = ie_q;
   assign TIMER_TICK_OUT = tick_q;

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   logic live;                                       // Word executes
   assign live = ex && !flush_q && !hold_q;
   sequence s_gap1;
      !cyc_end ##1 cyc_end;
   endsequence
   sequence s_gap3;
      !cyc_end [*3] ##1 cyc_end;
   endsequence
   property p_cyc2;
      cyc_end && !cyc4_q && !ctrl_q.cyc4 && !sleep_d |=> s_gap1;
   endproperty
   a_cyc2: assert property (p_cyc2) else $error("cycle not 2"); // [RL2]
   property p_cyc4;
      cyc_end && cyc4_q && ctrl_q.cyc4 && !sleep_d |=> s_gap3;
   endproperty
   a_cyc4: assert property (p_cyc4) else $error("cycle not 4"); // [RL5]
   property p_tick4;
      cyc_end && cyc4_q && ctrl_q.cyc4 && !sleep_d |=>
         TIMER_TICK_OUT ##1 !TIMER_TICK_OUT [*3] ##1 TIMER_TICK_OUT;
   endproperty
   a_tick4: assert property (p_tick4) else $error("tick rate"); // [RL6]
   property p_jump;
      live && w[12:10] == 3'b101 |=> pc_q == $past(tgt) && hold_q;
   endproperty
   a_jump: assert property (p_jump) else $error("jump target"); // [RL4]
   property p_call;
      live && w[12:10] == 3'b100 |=> stk_top == $past(pcn);
   endproperty
   a_call: assert property (p_call) else $error("call push"); // [RL12]
   property p_int_return;
      live && w == {7'h00, RETURN_FROM_INTERRUPT} |=>
         INT_EN_OUT && pc_q == $past(stk_top);
   endproperty
   a_int_return: assert property (p_int_return) else $error("irq"); // [RL11]
   property p_skip;
      live && skip |=> flush_q && pc_q == $past(pcn);
   endproperty
   a_skip: assert property (p_skip) else $error("skip"); // [RL19]
   property p_dec_skip;
      live && w[12:7] == 6'h0b && ra != R_STAT && rv == 8'h01 |=>
         flush_q && rf_q[R_STAT] == $past(rf_q[R_STAT]);
   endproperty
   a_dec_skip: assert property (p_dec_skip) else $error("dec skip"); // [RL13]
   property p_sleep;
      live && w == {7'h00, SLEEP_INSTR} |=> SLEEP_OUT && WDT_CLEAR_OUT
         ##1 SLEEP_OUT && !WDT_CLEAR_OUT && pc_q == $past(pc_q);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep"); // [RL10]
   property p_pcw;
      live && rf_we && rf_wa == R_PC |=> hold_q && pc_q[7:0] == $past(rf_wd);
   endproperty
   a_pcw: assert property (p_pcw) else $error("pc write"); // [RL3]
endmodule : mcu_decode_exec

// ---- bench/prog_mem_model.sv ----
// Purpose: Program memory holding two short fixed test programs
// Assumes: Combinational read, well inside the one-clock allowance
// Notes:   Unused addresses return no-operation words
`timescale 1ns/100ps
module prog_mem_model
(
   input  wire logic        ALT_IN,   // Second program select
   input  wire logic [12:0] ADDR_IN,  // Fetch address
   output logic      [12:0] DATA_OUT  // Instruction word
);
   // Program table; no bit set or clear on interrupt status
   always_comb
   begin
      case ({ALT_IN, ADDR_IN})
         14'h0000: DATA_OUT = 13'h1805;  // Load acc with 05
         14'h0001: DATA_OUT = 13'h0046;  // Store acc in reg 6
         14'h0002: DATA_OUT = 13'h1ffb;  // Add fb, wraps to zero
         14'h0003: DATA_OUT = 13'h0010;  // Interrupts on
         14'h0004: DATA_OUT = 13'h0586;  // Reg 6 minus one to acc
         14'h0005: DATA_OUT = 13'h1405;  // Jump to self
         // Second program: call, skips, pc write, sleep
         14'h2000: DATA_OUT = 13'h1801;  // Load acc with 01
         14'h2001: DATA_OUT = 13'h0047;  // Store acc in reg 7
         14'h2002: DATA_OUT = 13'h1010;  // Call 010
         14'h2003: DATA_OUT = 13'h1806;  // Load acc with 06
         14'h2004: DATA_OUT = 13'h0042;  // Acc into pc low byte
         14'h2005: DATA_OUT = 13'h1fff;  // Never reached
         14'h2006: DATA_OUT = 13'h0a07;  // Set bit 0 of reg 7
         14'h2007: DATA_OUT = 13'h0e07;  // Skip, bit 0 of reg 7 set
         14'h2008: DATA_OUT = 13'h1fff;  // Skipped
         14'h2009: DATA_OUT = 13'h0607;  // Rotate reg 7 right to acc
         14'h200a: DATA_OUT = 13'h0003;  // Sleep
         14'h2010: DATA_OUT = 13'h05c7;  // Reg 7 minus one, skip zero
         14'h2011: DATA_OUT = 13'h1fff;  // Skipped
         14'h2012: DATA_OUT = 13'h0013;  // Return, interrupts on
         default:  DATA_OUT = 13'h0000;  // No-operation
      endcase
   end
endmodule : prog_mem_model

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the instruction sequencer
// Assumes: APB slave answers with one wait state
// Notes:   Checks go through APB reads, the timer tick, the fetch address and the sleep, interrupt and watchdog outputs
`timescale 1ns/100ps
module testbench;
   import mcu_decode_pkg::*;
   logic            clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
   logic            alt = 0;            // Second program select
   logic [7:0]      paddr = 8'h00;      // Bus address
   logic [31:0]     pwdata = 32'h0, rd; // Write and read data
   logic            err, rdy, slverr, wdt, slp, ien, tick;
   logic [31:0]     prdata;             // Read data from slave
   logic [IW-1:0]   pm_data;            // Fetched word
   logic [PCW-1:0]  pm_addr;            // Fetch address
   int              fail_count = 0, comparisons = 0, cycles = 0, n;
   int              wdt_n = 0;          // Watchdog clear pulses
   // Clock of 25 ns
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   mcu_decode_exec i_dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PM_DATA_IN(pm_data), .PREADY_OUT(rdy),
      .PSLVERR_OUT(slverr), .PRDATA_OUT(prdata), .PM_ADDR_OUT(pm_addr),
      .WDT_CLEAR_OUT(wdt), .SLEEP_OUT(slp), .INT_EN_OUT(ien),
      .TIMER_TICK_OUT(tick));
   prog_mem_model i_pm (.ALT_IN(alt), .ADDR_IN(pm_addr),
      .DATA_OUT(pm_data));
   // Verdict and end of run
   task final_report;
      $display("Counts: %0d compares, %0d mismatches", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (wdt === 1'b1)
         wdt_n <= wdt_n + 1;
      if (cycles == 5000)
      begin
         fail_count++;
         final_report;
      end
   end
   // One APB transfer, held until ready is sampled
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = prdata;
      err = slverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      if (got !== exp)
         fail_count++;
   endtask : chk
   // Clocks between two timer ticks
   task period(output int p);
      p = 0;
      do @(posedge clk); while (tick !== 1'b1);
      do
      begin
         @(posedge clk);
         p++;
      end
      while (tick !== 1'b1);
   endtask : period
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd, {30'h0, CTRL_RST});
      apb(1'b0, 8'h0c, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, A_STAT, 32'hff);
      chk({31'h0, err}, 32'h1);
      $display("Test bus done");
      repeat (20) @(posedge clk);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd, 32'h0000_1e04);
      apb(1'b0, A_PC, 32'h0);
      chk(rd, 32'h5);
      chk({19'h0, pm_addr}, 32'h5);
      $display("Test program done");
      period(n);
      chk(n, 2);
      apb(1'b1, A_CTRL, 32'h3);
      period(n);
      period(n);
      chk(n, 4);
      $display("Test cycle length done");
      // Second program after a reset in mid-run
      rst <= 1'b1;
      alt <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (60) @(posedge clk);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd, 32'h0000_4700);
      apb(1'b0, A_PC, 32'h0);
      chk(rd, 32'hb);
      chk({30'h0, slp, ien}, 32'h3);
      chk(wdt_n, 32'h1);
      $display("Test second program done");
      final_report;
   end
endmodule : testbench
